/* src/tfs_pkg.sv */
package tfs_pkg;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned ADDR_W     = 11;
   localparam int unsigned MEM_DEPTH  = 2048;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam logic [3:0]  DEV_TYPE   = 4'ha;
   localparam logic [10:0] PROT_BASE  = 11'h400;
   localparam logic [3:0]  ACK_CNT    = 4'h8;
   localparam logic [3:0]  LAST_CNT   = 4'h7;
   localparam logic [2:0]  SYNC_IDLE  = 3'h7;
   localparam logic [1:0]  QTR_LAST   = 2'h3;
   // bus timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SCL_PERIOD_NS = 2500;
   // least quarter period, rounded up
   localparam int unsigned QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

   typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_WADDR, DS_WDATA, DS_RDATA} tfs_dst_t;
   typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BYTE, HS_STOP} tfs_hst_t;
   typedef enum logic [2:0] {SP_SAW, SP_WA, SP_WD, SP_SAR, SP_RD} tfs_step_t;
endpackage

/* src/tfs_if.sv */
`timescale 1ns/1ps
interface tfs_if;
   logic m_scl_o;
   logic m_scl_oe_n;
   logic m_sda_o;
   logic m_sda_oe_n;
   logic s_sda_o;
   logic s_sda_oe_n;
   logic scl;
   logic sda;

   // wired-and with pull-up
   assign scl = m_scl_oe_n | m_scl_o;
   assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

   modport dev  (input scl, input sda, output s_sda_o, output s_sda_oe_n);
   modport host (input scl, input sda, output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n);
endinterface

/* src/tfs_dev_end.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - start is data falling while clock high
// - start abandons everything, awaits slave address
// - stop is data rising, clock high; aborts
// - master holds data steady while clock high
// - ninth clock carries receiver's low acknowledge
// - missing acknowledge ends operation, back idle
// - master withholds acknowledge on last read
// - slave address upper nibble must be 1010
// - bits 3-1 page, bit 0 direction
// - write word address joins page bits
// - read keeps latched low byte, new page
// - latch increments per byte, wraps 7ffh
// - read sends byte, acknowledge means continue
// - all bytes travel most significant first
// - write commits at eighth bit, before acknowledge
// - early start or stop leaves memory alone
// - no busy time after any write
// - write protect guards 400h to 7ffh
// - protected byte: no acknowledge, no increment
// - read data drives from next clock on
// - master ends read by nack then stop
// - selective read uses write then restart
// - drive after clock fall, sample at rise
module tfs_dev_end #(
   parameter int unsigned MEM_DEPTH = tfs_pkg::MEM_DEPTH
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // user side
   input  wire logic wp,
   output logic      busy,
   // two-wire bus
   tfs_if.dev        bus
);

   ////////////////////////////////////////////////////////////////////////////////
   logic [2:0]                      scl_q;
   logic [2:0]                      sda_q;
   logic [1:0]                      wp_q;
   tfs_pkg::tfs_dst_t               st_q;
   logic [3:0]                      cnt_q;
   logic [7:0]                      sh_q;
   logic [7:0]                      ob_q;
   logic [10:0]                     addr_q;
   logic [2:0]                      page_q;
   logic                            ack_q;
   logic                            drv_q;
   logic [7:0]                      mem_q [MEM_DEPTH];

   wire                             scl_s    = scl_q[1];
   wire                             scl_p    = scl_q[2];
   wire                             sda_s    = sda_q[1];
   wire                             sda_p    = sda_q[2];
   wire                             wp_s     = wp_q[1];
   wire                             start_w  = scl_s & scl_p & sda_p & ~sda_s;
   wire                             stop_w   = scl_s & scl_p & ~sda_p & sda_s;
   wire                             rise_w   = scl_s & ~scl_p;
   wire                             fall_w   = ~scl_s & scl_p;
   wire                             act_w    = st_q != tfs_pkg::DS_IDLE;
   wire                             slot_w   = cnt_q == tfs_pkg::ACK_CNT;
   wire                             last_w   = cnt_q == tfs_pkg::LAST_CNT;
   wire [7:0]                       byte_w   = {sh_q[6:0], sda_s};
   wire                             match_w  = byte_w[7:4] == tfs_pkg::DEV_TYPE;
   wire                             prot_w   = wp_s & (addr_q >= tfs_pkg::PROT_BASE);
   wire                             bit_w    = ~start_w & ~stop_w & act_w & rise_w & ~slot_w;
   wire                             commit_w = bit_w & last_w & (st_q == tfs_pkg::DS_WDATA) & ~prot_w;
   wire                             m_nack_w = (st_q == tfs_pkg::DS_RDATA) & ~ack_q & sda_s;
   wire                             own_nk_w = (st_q != tfs_pkg::DS_RDATA) & ~ack_q;

   assign busy           = act_w;
   assign bus.s_sda_o    = 1'b0;
   assign bus.s_sda_oe_n = ~drv_q;

   ////////////////////////////////////////////////////////////////////////////////
   // pins cross in through two flops; third stage is edge history only
   always_ff @(posedge clk) begin
      if (rst) begin
         scl_q <= tfs_pkg::SYNC_IDLE;
         sda_q <= tfs_pkg::SYNC_IDLE;
         wp_q  <= '0;
      end else begin
         scl_q <= {scl_q[1:0], bus.scl};
         sda_q <= {sda_q[1:0], bus.sda};
         wp_q  <= {wp_q[0], wp};
      end
   end

   // array write lands at the eighth rise, long before the ack drive
   always_ff @(posedge clk) begin
      if (commit_w) begin
         mem_q[addr_q] <= byte_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q   <= tfs_pkg::DS_IDLE;
         cnt_q  <= '0;
         sh_q   <= '0;
         ob_q   <= '0;
         addr_q <= '0;
         page_q <= '0;
         ack_q  <= 1'b0;
         drv_q  <= 1'b0;
      end else if (start_w) begin
         st_q  <= tfs_pkg::DS_ADDR;
         cnt_q <= '0;
         ack_q <= 1'b0;
         drv_q <= 1'b0;
      end else if (stop_w) begin
         st_q  <= tfs_pkg::DS_IDLE;
         ack_q <= 1'b0;
         drv_q <= 1'b0;
      end else if (act_w && rise_w && !slot_w) begin
         sh_q  <= byte_w;
         cnt_q <= cnt_q + 4'h1;
         if (last_w) begin
            case (st_q)
               tfs_pkg::DS_ADDR: begin
                  if (!match_w) begin
                     st_q <= tfs_pkg::DS_IDLE;
                  end else if (byte_w[0]) begin
                     ack_q  <= 1'b1;
                     st_q   <= tfs_pkg::DS_RDATA;
                     addr_q <= {byte_w[3:1], addr_q[7:0]};
                  end else begin
                     ack_q  <= 1'b1;
                     st_q   <= tfs_pkg::DS_WADDR;
                     page_q <= byte_w[3:1];
                  end
               end
               tfs_pkg::DS_WADDR: begin
                  addr_q <= {page_q, byte_w};
                  ack_q  <= 1'b1;
                  st_q   <= tfs_pkg::DS_WDATA;
               end
               tfs_pkg::DS_WDATA: begin
                  ack_q <= ~prot_w;
                  if (!prot_w) begin
                     addr_q <= addr_q + 11'h1;
                  end
               end
               tfs_pkg::DS_RDATA: begin
                  ack_q  <= 1'b0;
                  addr_q <= addr_q + 11'h1;
               end
               default: st_q <= tfs_pkg::DS_IDLE;
            endcase
         end
      end else if (act_w && rise_w) begin
         // ninth rise: acknowledge slot
         cnt_q <= '0;
         ack_q <= 1'b0;
         ob_q  <= mem_q[addr_q];
         if (m_nack_w || own_nk_w) begin
            st_q <= tfs_pkg::DS_IDLE;
         end
      end else if (act_w && fall_w) begin
         if (slot_w) begin
            drv_q <= ack_q;
         end else if (st_q == tfs_pkg::DS_RDATA) begin
            drv_q <= ~ob_q[7];
            ob_q  <= {ob_q[6:0], 1'b0};
         end else begin
            drv_q <= 1'b0;
         end
      end
   end

endmodule // tfs_dev_end

/* src/tfs_host_end.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tfs_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0]             mem_q [DEPTH];
   logic [AW-1:0]                wp_q;
   logic [AW-1:0]                rp_q;
   logic [AW:0]                  cnt_q;

   wire                          push_w = in_valid & in_ready;
   wire                          pop_w  = out_valid & out_ready;

   assign in_ready  = cnt_q != (AW+1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data  = mem_q[rp_q];

   always_ff @(posedge clk) begin
      if (push_w) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push_w) begin
            wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
         end
         if (pop_w) begin
            rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
         end
         cnt_q <= cnt_q + (AW+1)'(push_w) - (AW+1)'(pop_w);
      end
   end
endmodule // tfs_fifo

////////////////////////////////////////////////////////////////////////////////
module tfs_host_end #(
   parameter int unsigned QTR_CYC = tfs_pkg::QTR_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // command
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic        cmd_rd,
   input  wire logic [10:0] cmd_addr,
   input  wire logic [7:0]  cmd_len,
   // write data
   input  wire logic        wr_valid,
   output logic             wr_ready,
   input  wire logic [7:0]  wr_data,
   // read data
   output logic             rd_valid,
   input  wire logic        rd_ready,
   output logic [7:0]       rd_data,
   // status
   output logic             done,
   output logic             nack,
   // two-wire bus
   tfs_if.host              bus
);
   tfs_pkg::tfs_hst_t       st_q;
   tfs_pkg::tfs_step_t      step_q;
   logic [15:0]             div_q;
   logic [1:0]              ph_q;
   logic [3:0]              bit_q;
   logic [7:0]              sh_q;
   logic [7:0]              rx_q;
   logic [7:0]              len_q;
   logic [10:0]             addr_q;
   logic                    rd_q;
   logic                    ackn_q;
   logic                    scl_low_q;
   logic                    sda_low_q;
   logic                    done_q;
   logic                    nack_q;
   logic [1:0]              sda_q;
   logic                    f_ready;

   wire                     sda_s   = sda_q[1];
   wire                     tick_w  = div_q == 16'(QTR_CYC - 1);
   wire                     byte_w  = st_q == tfs_pkg::HS_BYTE;
   wire                     wd_w    = step_q == tfs_pkg::SP_WD;
   wire                     rdst_w  = step_q == tfs_pkg::SP_RD;
   wire                     ph0_w   = ph_q == 2'h0;
   wire                     slot_w  = bit_q == tfs_pkg::ACK_CNT;
   wire                     wstall  = wd_w & (bit_q == 4'h0) & ~wr_valid;
   // full fifo holds the clock before the ack slot
   wire                     rstall  = rdst_w & slot_w & ~f_ready;
   wire                     go_w    = tick_w & (st_q != tfs_pkg::HS_IDLE) & ~(byte_w & ph0_w & (wstall | rstall));
   wire [7:0]               txb_w   = (wd_w && bit_q == 4'h0) ? wr_data : sh_q;
   wire [7:0]               sar_w   = {tfs_pkg::DEV_TYPE, addr_q[10:8], 1'b1};
   wire                     last_w  = len_q == 8'h1;
   wire                     fail_w  = ackn_q & ~rdst_w;

   assign cmd_ready      = st_q == tfs_pkg::HS_IDLE;
   assign wr_ready       = go_w & byte_w & ph0_w & wd_w & (bit_q == 4'h0);
   assign done           = done_q;
   assign nack           = nack_q;
   assign bus.m_scl_o    = 1'b0;
   assign bus.m_scl_oe_n = ~scl_low_q;
   assign bus.m_sda_o    = 1'b0;
   assign bus.m_sda_oe_n = ~sda_low_q;

   tfs_fifo #(
      .WIDTH (tfs_pkg::DATA_W),
      .DEPTH (tfs_pkg::FIFO_DEPTH)
   ) i_tfs_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (go_w & byte_w & ph0_w & rdst_w & slot_w),
      .in_ready  (f_ready),
      .in_data   (rx_q),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         sda_q <= '1;
         div_q <= '0;
      end else begin
         sda_q <= {sda_q[0], bus.sda};
         div_q <= tick_w ? '0 : div_q + 16'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q      <= tfs_pkg::HS_IDLE;
         step_q    <= tfs_pkg::SP_SAW;
         ph_q      <= '0;
         bit_q     <= '0;
         sh_q      <= '0;
         rx_q      <= '0;
         len_q     <= '0;
         addr_q    <= '0;
         rd_q      <= 1'b0;
         ackn_q    <= 1'b0;
         scl_low_q <= 1'b0;
         sda_low_q <= 1'b0;
         done_q    <= 1'b0;
         nack_q    <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (st_q == tfs_pkg::HS_IDLE && cmd_valid) begin
            st_q   <= tfs_pkg::HS_START;
            step_q <= tfs_pkg::SP_SAW;
            sh_q   <= {tfs_pkg::DEV_TYPE, cmd_addr[10:8], 1'b0};
            len_q  <= (cmd_rd && cmd_len == 8'h0) ? 8'h1 : cmd_len;
            rd_q   <= cmd_rd;
            addr_q <= cmd_addr;
            nack_q <= 1'b0;
         end else if (go_w) begin
            ph_q <= ph_q + 2'h1;
            case (st_q)
               tfs_pkg::HS_START: begin
                  // scl low on entry for a repeated start
                  case (ph_q)
                     2'h0: sda_low_q <= 1'b0;
                     2'h1: scl_low_q <= 1'b0;
                     2'h2: sda_low_q <= 1'b1;
                     default: begin
                        scl_low_q <= 1'b1;
                        st_q      <= tfs_pkg::HS_BYTE;
                        bit_q     <= '0;
                     end
                  endcase
               end
               tfs_pkg::HS_STOP: begin
                  case (ph_q)
                     2'h0: sda_low_q <= 1'b1;
                     2'h1: scl_low_q <= 1'b0;
                     2'h2: sda_low_q <= 1'b0;
                     default: begin
                        st_q   <= tfs_pkg::HS_IDLE;
                        done_q <= 1'b1;
                     end
                  endcase
               end
               tfs_pkg::HS_BYTE: begin
                  case (ph_q)
                     2'h0: begin
                        if (slot_w) begin
                           sda_low_q <= rdst_w & ~last_w;
                        end else if (rdst_w) begin
                           sda_low_q <= 1'b0;
                        end else begin
                           sda_low_q <= ~txb_w[7];
                           sh_q      <= {txb_w[6:0], 1'b0};
                        end
                     end
                     2'h1: scl_low_q <= 1'b0;
                     2'h2: begin
                        if (slot_w) begin
                           ackn_q <= sda_s;
                        end else begin
                           rx_q <= {rx_q[6:0], sda_s};
                        end
                     end
                     default: begin
                        scl_low_q <= 1'b1;
                        bit_q     <= slot_w ? 4'h0 : bit_q + 4'h1;
                        if (slot_w && fail_w) begin
                           st_q   <= tfs_pkg::HS_STOP;
                           nack_q <= 1'b1;
                        end else if (slot_w) begin
                           case (step_q)
                              tfs_pkg::SP_SAW: begin
                                 step_q <= tfs_pkg::SP_WA;
                                 sh_q   <= addr_q[7:0];
                              end
                              tfs_pkg::SP_WA: begin
                                 if (rd_q) begin
                                    st_q   <= tfs_pkg::HS_START;
                                    step_q <= tfs_pkg::SP_SAR;
                                    sh_q   <= sar_w;
                                 end else if (len_q == 8'h0) begin
                                    st_q <= tfs_pkg::HS_STOP;
                                 end else begin
                                    step_q <= tfs_pkg::SP_WD;
                                 end
                              end
                              tfs_pkg::SP_SAR: step_q <= tfs_pkg::SP_RD;
                              default: begin
                                 len_q <= len_q - 8'h1;
                                 if (last_w) begin
                                    st_q <= tfs_pkg::HS_STOP;
                                 end
                              end
                           endcase
                        end
                     end
                  endcase
               end
               default: st_q <= tfs_pkg::HS_IDLE;
            endcase
         end
      end
   end
endmodule // tfs_host_end

/* verification/tfs_link_asserts.sv */
`timescale 1ns/1ps
module tfs_link_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host drives
   input wire logic m_scl_o,
   input wire logic m_scl_oe_n,
   input wire logic m_sda_o,
   input wire logic m_sda_oe_n,
   // device drives
   input wire logic s_sda_o,
   input wire logic s_sda_oe_n,
   // resolved wires
   input wire logic scl,
   input wire logic sda
);
   logic       scl_q;
   logic       sda_q;
   logic       framed_q;
   logic       first_q;
   logic [3:0] cnt_q;
   wire        start_w = scl & scl_q & sda_q & ~sda;
   wire        stop_w  = scl & scl_q & ~sda_q & sda;
   wire        rise_w  = scl & ~scl_q;

   ////////////////////////////////////////////////////////////////////////////////
   // rises counted per byte, 9 is the acknowledge slot; a stop in the 10th clock reads as bit 1
   always_ff @(posedge clk) begin
      scl_q    <= rst | scl;
      sda_q    <= rst | sda;
      framed_q <= ~rst & ~stop_w & (start_w | framed_q);
      first_q  <= ~rst & (start_w | (first_q & ~(rise_w & cnt_q == 4'h8)));
      if (rst || start_w || stop_w) begin
         cnt_q <= 4'h0;
      end else if (rise_w) begin
         cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_stop; scl && $past(scl) && $rose(sda); endsequence
   sequence s_quiet; s_sda_oe_n [*8]; endsequence
   // data may move with the clock high only around start and stop or in a byte's first bit, never later in a byte
   property p_data_steady; scl && $past(scl) && $changed(sda) |-> cnt_q <= 4'h1; endproperty
   property p_framed; $fell(scl) |-> framed_q; endproperty
   property p_stop_own; s_stop |-> $past(s_sda_oe_n) && $past(!m_sda_oe_n); endproperty
   property p_stop_quiet; s_stop |=> s_quiet; endproperty
   property p_drive_fall; $fell(s_sda_oe_n) |-> !scl && !$past(scl, 2); endproperty
   property p_hold_high; scl && $past(scl) && $past(!s_sda_oe_n) |-> !s_sda_oe_n && $stable(s_sda_o); endproperty
   property p_addr_rx; framed_q && first_q && cnt_q < 4'h8 |-> s_sda_oe_n; endproperty
   property p_ack_stable; scl && $past(scl) && cnt_q == 4'h9 && $past(cnt_q) == 4'h9 |-> $stable(sda); endproperty
   a_data_steady:
      assert property (p_data_steady) else $error("data moved while clock high");
   a_framed:
      assert property (p_framed) else $error("clock toggled outside a frame");
   a_stop_own:
      assert property (p_stop_own) else $error("stop while device held data");
   a_stop_quiet:
      assert property (p_stop_quiet) else $error("device drove after stop");
   a_drive_fall:
      assert property (p_drive_fall) else $error("device drive not after clock fall");
   a_hold_high:
      assert property (p_hold_high) else $error("device data moved while clock high");
   a_addr_rx:
      assert property (p_addr_rx) else $error("device drove during slave address");
   a_ack_stable:
      assert property (p_ack_stable) else $error("acknowledge slot unstable");
endmodule // tfs_link_asserts

/* verification/two_wire_fram_slave_port_tb.sv */
`timescale 1ns/1ps
module two_wire_fram_slave_port_tb;
   logic        clk        = 1'b0;
   logic        rst        = 1'b1;
   logic        wp         = 1'b0;
   logic        cmd_valid  = 1'b0;
   logic        cmd_rd     = 1'b0;
   logic [10:0] cmd_addr   = 11'h000;
   logic [7:0]  cmd_len    = 8'h00;
   logic        wr_valid   = 1'b0;
   logic [7:0]  wr_data    = 8'h00;
   logic        rd_ready   = 1'b0;
   logic        b_scl_oe_n = 1'b1;
   logic        b_sda_oe_n = 1'b1;
   wire         cmd_ready, wr_ready, rd_valid, done, nack, busy, busy_b;
   wire  [7:0]  rd_data;
   int          err_count   = 0;
   int          comparisons = 0;
   int          cyc;
   logic [7:0]  buf_q[$];
   logic [7:0]  rx_q[$];

   always #5 clk = ~clk;
   tfs_if bus();
   tfs_if bus2();
   // second link: bench plays the master, may break its rules
   assign bus2.m_scl_o    = 1'b0;
   assign bus2.m_sda_o    = 1'b0;
   assign bus2.m_scl_oe_n = b_scl_oe_n;
   assign bus2.m_sda_oe_n = b_sda_oe_n;
   tfs_host_end #(.QTR_CYC(8)) i_tfs_host_end (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
      .done(done), .nack(nack), .bus(bus));
   tfs_dev_end i_tfs_dev_end (.clk(clk), .rst(rst), .wp(wp), .busy(busy), .bus(bus));
   tfs_dev_end i_tfs_dev_end_b (.clk(clk), .rst(rst), .wp(1'b0), .busy(busy_b), .bus(bus2));
   tfs_link_asserts i_tfs_link_asserts (.clk(clk), .rst(rst), .m_scl_o(bus.m_scl_o),
      .m_scl_oe_n(bus.m_scl_oe_n), .m_sda_o(bus.m_sda_o), .m_sda_oe_n(bus.m_sda_oe_n),
      .s_sda_o(bus.s_sda_o), .s_sda_oe_n(bus.s_sda_oe_n), .scl(bus.scl), .sda(bus.sda));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (!ok) begin
         err_count++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic bq(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one command through the host end; read data held back for stall cycles
   task automatic run(input logic rd, input logic [10:0] a, input int n, input int stall);
      int   i;
      logic tk;
      i = 0;
      rx_q.delete();
      cmd_valid = 1'b1;
      cmd_rd = rd;
      cmd_addr = a;
      cmd_len = 8'(n);
      for (cyc = 0; cyc < 30000; cyc++) begin
         @(posedge clk);
         tk = cmd_ready;
         if (done === 1'b1) break;
         if (rd_valid && rd_ready) rx_q.push_back(rd_data);
         if (wr_valid && wr_ready) i++;
         #1;
         cmd_valid = cmd_valid && !tk;
         wr_valid = !rd && !cmd_valid && i < n;
         wr_data = (i < buf_q.size()) ? buf_q[i] : 8'h00;
         rd_ready = rd && cyc >= stall;
      end
      #1;
      wr_valid = 1'b0;
      rd_ready = 1'b0;
      if (cyc == 30000) begin
         err_count++;
         $display("mismatch at %0t: no done", $time);
         conclude();
      end
   endtask
   // 80 ns link clock bit: data set in low phase, sampled in high phase
   task automatic bb_bit(input logic b, output logic r);
      b_scl_oe_n = 1'b0;
      bq(1);
      b_sda_oe_n = b;
      bq(3);
      b_scl_oe_n = 1'b1;
      bq(2);
      r = bus2.sda;
      bq(2);
   endtask
   task automatic bb_start();
      b_scl_oe_n = 1'b0;
      bq(2);
      b_sda_oe_n = 1'b1;
      bq(2);
      b_scl_oe_n = 1'b1;
      bq(4);
      b_sda_oe_n = 1'b0;
      bq(4);
   endtask
   task automatic bb_byte(input logic [7:0] d, input logic m, output logic a, output logic [7:0] q);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bb_bit(d[i], r);
         q[i] = r;
      end
      bb_bit(m, r);
      a = ~r;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_wrap();
      buf_q = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88, 8'h99, 8'haa};
      run(1'b0, 11'h7fb, 10, 0);
      chk(nack === 1'b0, "write refused");
      run(1'b1, 11'h7fb, 10, 6000);
      chk(cyc > 6000, "full buffer did not stall the link");
      chk(rx_q.size() == 10, "read count");
      for (int i = 0; i < 10; i++) chk(rx_q[i] === buf_q[i], "wrapped data");
      $display("test wrap done");
   endtask
   task automatic t_protect();
      buf_q = {8'h5a};
      run(1'b0, 11'h400, 1, 0);
      wp = 1'b1;
      buf_q = {8'ha5, 8'h3c};
      run(1'b0, 11'h400, 2, 0);
      chk(nack === 1'b1, "protected byte acknowledged");
      chk(busy === 1'b0, "device busy after stop");
      buf_q = {8'hc3};
      run(1'b0, 11'h3ff, 1, 0);
      chk(nack === 1'b0, "lower half refused");
      run(1'b1, 11'h3ff, 2, 0);
      chk(rx_q[0] === 8'hc3 && rx_q[1] === 8'h5a, "protect readback");
      chk(rd_valid === 1'b0, "read buffer not drained");
      wp = 1'b0;
      $display("test protect done");
   endtask
   task automatic t_link();
      logic       a;
      logic       r;
      logic [7:0] q;
      bb_start();
      bb_byte(8'h52, 1'b1, a, q);
      chk(a === 1'b0 && busy_b === 1'b0, "foreign type answered");
      bb_byte(8'ha0, 1'b1, a, q);
      chk(a === 1'b0, "ignored bus answered");
      bb_start();
      bb_byte(8'ha0, 1'b1, a, q);
      chk(a === 1'b1, "address after start");
      bb_byte(8'h10, 1'b1, a, q);
      bb_byte(8'h3c, 1'b1, a, q);
      chk(a === 1'b1, "data byte");
      bb_start();
      bb_byte(8'ha0, 1'b1, a, q);
      bb_byte(8'h10, 1'b1, a, q);
      for (int i = 7; i > 3; i--) bb_bit(i > 5, r);
      bb_bit(1'b0, r);
      b_sda_oe_n = 1'b1;
      bq(4);
      bb_start();
      bb_byte(8'ha0, 1'b1, a, q);
      bb_byte(8'h10, 1'b1, a, q);
      bb_start();
      bb_byte(8'ha1, 1'b1, a, q);
      bb_byte(8'hff, 1'b1, a, q);
      chk(q === 8'h3c, "early stop altered memory");
      bb_bit(1'b0, r);
      b_sda_oe_n = 1'b1;
      bq(4);
      $display("test link done");
   endtask

   initial begin
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      bq(3);
      t_wrap();
      t_protect();
      t_link();
      conclude();
   end
endmodule // two_wire_fram_slave_port_tb
